// *** hdl/bt_pkg.sv ***
// Shared constants and carrier types for the block-transfer host mailbox.
package bt_pkg;

    // Host I/O window: three adjacent byte locations selected by the two low address lines.
    localparam int HOST_ADDR_W = 16;
    localparam int WINDOW_LOCATIONS = 3;
    localparam logic [HOST_ADDR_W-1:0] DEFAULT_IO_BASE = 16'h00e4;
    localparam logic [1:0] OFS_CONTROL = 2'h0;
    localparam logic [1:0] OFS_BUFFER = 2'h1;
    localparam logic [1:0] OFS_MASK = 2'h2;

    // Message buffer geometry.
    localparam int DEFAULT_DEPTH = 64;
    localparam int BUF_IDX_W = 8;

    // Bit positions of transfer_control.
    localparam int CTL_CLR_WR_PTR = 0;
    localparam int CTL_CLR_RD_PTR = 1;
    localparam int CTL_REQ_ATN = 2;
    localparam int CTL_RSP_ATN = 3;
    localparam int CTL_SW_ATN = 4;
    localparam int CTL_HOST_BUSY = 6;
    localparam int CTL_CTRL_BUSY = 7;

    // Bit positions of interrupt_mask.
    localparam int MSK_IRQ_EN = 0;
    localparam int MSK_IRQ_PEND = 1;

    // Values after reset.
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Message byte positions, counted from zero.
    localparam logic [BUF_IDX_W-1:0] MSG_LEN_IDX = 8'h00;
    localparam logic [BUF_IDX_W-1:0] REQ_DATA_IDX = 8'h04;
    localparam logic [BUF_IDX_W-1:0] RSP_CC_IDX = 8'h04;
    localparam logic [BUF_IDX_W-1:0] RSP_DATA_IDX = 8'h05;
    // Smallest response length byte: function_and_unit, sequence, command, completion code.
    localparam logic [7:0] RSP_MIN_LEN = 8'h04;

    // One host I/O cycle, valid for a single clock.
    typedef struct packed {
        logic [HOST_ADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } host_req_s;

    // Controller-side requests, strobes valid for a single clock.
    typedef struct packed {
        logic rsp_wr;
        logic [BUF_IDX_W-1:0] rsp_idx;
        logic [7:0] rsp_data;
        logic [BUF_IDX_W-1:0] req_idx;
        logic set_rsp_atn;
        logic set_sw_atn;
        logic clr_req_atn;
        logic busy;
    } ctl_req_s;

endpackage

// *** hdl/msg_buffer.sv ***
// Byte-wide message buffer held in flip-flops with one write and one read index.
`timescale 1ns/1ps
module msg_buffer #(
    parameter int DEPTH = 64,
    parameter int IDX_W = $clog2(DEPTH)
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wr_en_i,
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [IDX_W-1:0] rd_idx_i,
    output logic [7:0] rd_data_o
);
    import bt_pkg::*;

    logic [7:0] store [DEPTH];

    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
        logic [7:0] byte_r;
        logic [7:0] byte_nxt;

        always_comb begin
            byte_nxt = byte_r;
            if (wr_en_i && wr_idx_i == IDX_W'(g)) begin
                byte_nxt = wr_data_i;
            end
        end

        always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
                byte_r <= BYTE_RST;
            end else begin
                byte_r <= byte_nxt;
            end
        end

        assign store[g] = byte_r;
    end

    // The read is combinational from the flops; the caller registers it.
    assign rd_data_o = store[rd_idx_i];

endmodule // msg_buffer

// *** hdl/block_transfer_host_mailbox.sv ***
// Block-transfer message mailbox between host I/O space and the management controller.
`timescale 1ns/1ps
module block_transfer_host_mailbox #(
    parameter int DEPTH = bt_pkg::DEFAULT_DEPTH,
    parameter logic [bt_pkg::HOST_ADDR_W-1:0] IO_BASE = bt_pkg::DEFAULT_IO_BASE
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire bt_pkg::host_req_s host_req_i,
    output logic [7:0] host_rdata_o,
    output logic host_irq_o,
    input wire bt_pkg::ctl_req_s ctl_req_i,
    output logic [7:0] ctl_req_data_o,
    output logic ctl_req_atn_o,
    output logic ctl_host_busy_o,
    output logic ctl_rsp_refused_o
);
    import bt_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);

    // A full-address region compare stands in for the board's general-purpose
    // chip select; inside the region only the two low lines choose a location.
    function automatic logic window_hit(input logic [HOST_ADDR_W-1:0] addr);
        logic region;
        region = (addr[HOST_ADDR_W-1:2] == IO_BASE[HOST_ADDR_W-1:2]);
        return region && (addr[1:0] <= 2'(WINDOW_LOCATIONS - 1));
    endfunction

    function automatic logic at_offset(input host_req_s req, input logic [1:0] ofs);
        return window_hit(req.addr) && (req.addr[1:0] == ofs);
    endfunction

    // Decoded host accesses, each a one-cycle event.
    logic wr_control;
    logic wr_buffer;
    logic wr_mask;
    logic rd_control;
    logic rd_buffer;
    logic rd_mask;

    always_comb begin
        wr_control = host_req_i.wr && at_offset(host_req_i, OFS_CONTROL);
        wr_buffer = host_req_i.wr && at_offset(host_req_i, OFS_BUFFER);
        wr_mask = host_req_i.wr && at_offset(host_req_i, OFS_MASK);
        rd_control = host_req_i.rd && at_offset(host_req_i, OFS_CONTROL);
        rd_buffer = host_req_i.rd && at_offset(host_req_i, OFS_BUFFER);
        rd_mask = host_req_i.rd && at_offset(host_req_i, OFS_MASK);
    end

    // Byte pointers of the two buffers.
    logic [IDX_W-1:0] wr_ptr_r;
    logic [IDX_W-1:0] wr_ptr_nxt;
    logic [IDX_W-1:0] rd_ptr_r;
    logic [IDX_W-1:0] rd_ptr_nxt;

    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        if (wr_control && host_req_i.wdata[CTL_CLR_WR_PTR]) begin
            wr_ptr_nxt = '0;
        end else if (wr_buffer) begin
            wr_ptr_nxt = wr_ptr_r + IDX_W'(1);
        end
        if (wr_control && host_req_i.wdata[CTL_CLR_RD_PTR]) begin
            rd_ptr_nxt = '0;
        end else if (rd_buffer) begin
            rd_ptr_nxt = rd_ptr_r + IDX_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
        end
    end

    // The two directions have separate storage, so the host may load the next
    // request while an earlier response is still waiting to be read.
    logic [7:0] from_host_rd_data;
    logic [7:0] to_host_rd_data;

    msg_buffer #(
        .DEPTH(DEPTH),
        .IDX_W(IDX_W)
    ) u_from_host_buffer (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .wr_en_i(wr_buffer),
        .wr_idx_i(wr_ptr_r),
        .wr_data_i(host_req_i.wdata),
        .rd_idx_i(IDX_W'(ctl_req_i.req_idx)),
        .rd_data_o(from_host_rd_data)
    );

    msg_buffer #(
        .DEPTH(DEPTH),
        .IDX_W(IDX_W)
    ) u_to_host_buffer (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .wr_en_i(ctl_req_i.rsp_wr),
        .wr_idx_i(IDX_W'(ctl_req_i.rsp_idx)),
        .wr_data_i(ctl_req_i.rsp_data),
        .rd_idx_i(rd_ptr_r),
        .rd_data_o(to_host_rd_data)
    );

    // Attention, busy and interrupt state.
    logic req_atn_r;
    logic req_atn_nxt;
    logic rsp_atn_r;
    logic rsp_atn_nxt;
    logic sw_atn_r;
    logic sw_atn_nxt;
    logic host_busy_r;
    logic host_busy_nxt;
    logic ctrl_busy_r;
    logic ctrl_busy_nxt;
    logic irq_en_r;
    logic irq_en_nxt;
    logic irq_pend_r;
    logic irq_pend_nxt;
    logic [7:0] rsp_len_r;
    logic [7:0] rsp_len_nxt;
    logic refused_r;
    logic refused_nxt;
    logic rsp_accept;
    logic rsp_rise;
    logic sw_rise;

    always_comb begin
        rsp_len_nxt = rsp_len_r;
        if (ctl_req_i.rsp_wr && ctl_req_i.rsp_idx == MSG_LEN_IDX) begin
            rsp_len_nxt = ctl_req_i.rsp_data;
        end

        // A response too short to hold its completion code is refused, so the
        // host never sees attention for a message without one.
        rsp_accept = ctl_req_i.set_rsp_atn && (rsp_len_r >= RSP_MIN_LEN);
        rsp_rise = rsp_accept && !rsp_atn_r;
        sw_rise = ctl_req_i.set_sw_atn && !sw_atn_r;
        refused_nxt = ctl_req_i.set_rsp_atn && !rsp_accept;

        // Each flag's set is taken after its clear, so a set in the same cycle wins.
        req_atn_nxt = req_atn_r;
        if (ctl_req_i.clr_req_atn) begin
            req_atn_nxt = 1'b0;
        end
        if (wr_control && host_req_i.wdata[CTL_REQ_ATN]) begin
            req_atn_nxt = 1'b1;
        end

        rsp_atn_nxt = rsp_atn_r;
        if (wr_control && host_req_i.wdata[CTL_RSP_ATN]) begin
            rsp_atn_nxt = 1'b0;
        end
        if (rsp_accept) begin
            rsp_atn_nxt = 1'b1;
        end

        sw_atn_nxt = sw_atn_r;
        if (wr_control && host_req_i.wdata[CTL_SW_ATN]) begin
            sw_atn_nxt = 1'b0;
        end
        if (ctl_req_i.set_sw_atn) begin
            sw_atn_nxt = 1'b1;
        end

        host_busy_nxt = host_busy_r;
        if (wr_control && host_req_i.wdata[CTL_HOST_BUSY]) begin
            host_busy_nxt = !host_busy_r;
        end
        ctrl_busy_nxt = ctl_req_i.busy;

        irq_en_nxt = irq_en_r;
        if (wr_mask) begin
            irq_en_nxt = host_req_i.wdata[MSK_IRQ_EN];
        end
        irq_pend_nxt = irq_pend_r;
        if (wr_mask && host_req_i.wdata[MSK_IRQ_PEND]) begin
            irq_pend_nxt = 1'b0;
        end
        if (rsp_rise || sw_rise) begin
            irq_pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            req_atn_r <= 1'b0;
            rsp_atn_r <= 1'b0;
            sw_atn_r <= 1'b0;
            host_busy_r <= 1'b0;
            ctrl_busy_r <= 1'b0;
            irq_en_r <= 1'b0;
            irq_pend_r <= 1'b0;
            rsp_len_r <= BYTE_RST;
            refused_r <= 1'b0;
        end else begin
            req_atn_r <= req_atn_nxt;
            rsp_atn_r <= rsp_atn_nxt;
            sw_atn_r <= sw_atn_nxt;
            host_busy_r <= host_busy_nxt;
            ctrl_busy_r <= ctrl_busy_nxt;
            irq_en_r <= irq_en_nxt;
            irq_pend_r <= irq_pend_nxt;
            rsp_len_r <= rsp_len_nxt;
            refused_r <= refused_nxt;
        end
    end

    // Read data for both parties: the host byte is held until its next read, the controller byte follows req_idx every clock.
    logic [7:0] control_view;
    logic [7:0] mask_view;
    logic [7:0] host_rdata_r;
    logic [7:0] host_rdata_nxt;
    logic [7:0] req_data_r;
    logic [7:0] req_data_nxt;

    always_comb begin
        // The attention bits stay readable with the interrupt off or on.
        control_view = 8'h00;
        control_view[CTL_REQ_ATN] = req_atn_r;
        control_view[CTL_RSP_ATN] = rsp_atn_r;
        control_view[CTL_SW_ATN] = sw_atn_r;
        control_view[CTL_HOST_BUSY] = host_busy_r;
        control_view[CTL_CTRL_BUSY] = ctrl_busy_r;
        mask_view = 8'h00;
        mask_view[MSK_IRQ_EN] = irq_en_r;
        mask_view[MSK_IRQ_PEND] = irq_pend_r;

        host_rdata_nxt = host_rdata_r;
        if (rd_control) begin
            host_rdata_nxt = control_view;
        end else if (rd_buffer) begin
            host_rdata_nxt = to_host_rd_data;
        end else if (rd_mask) begin
            host_rdata_nxt = mask_view;
        end else if (host_req_i.rd) begin
            host_rdata_nxt = 8'h00;
        end
        req_data_nxt = from_host_rd_data;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            host_rdata_r <= RDATA_RST;
            req_data_r <= RDATA_RST;
        end else begin
            host_rdata_r <= host_rdata_nxt;
            req_data_r <= req_data_nxt;
        end
    end

    assign host_rdata_o = host_rdata_r;
    assign ctl_req_data_o = req_data_r;
    assign ctl_req_atn_o = req_atn_r;
    assign ctl_host_busy_o = host_busy_r;
    assign ctl_rsp_refused_o = refused_r;
    assign host_irq_o = irq_en_r && irq_pend_r;

endmodule // block_transfer_host_mailbox

// *** verif/bt_mailbox_props.sv ***
// Port assertions for the block-transfer host mailbox.
`timescale 1ns/1ps
module bt_mailbox_props #(
    parameter int DEPTH = 64,
    parameter logic [15:0] IO_BASE = 16'h00e4
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire bt_pkg::host_req_s host_req_i,
    input wire logic [7:0] host_rdata_o,
    input wire logic host_irq_o,
    input wire bt_pkg::ctl_req_s ctl_req_i,
    input wire logic [7:0] ctl_req_data_o,
    input wire logic ctl_req_atn_o,
    input wire logic ctl_host_busy_o,
    input wire logic ctl_rsp_refused_o
);
    import bt_pkg::*;
    logic win;
    logic cw;
    logic mw;
    assign win = host_req_i.addr[15:2] == IO_BASE[15:2] && host_req_i.addr[1:0] != 2'h3;
    assign cw = host_req_i.wr && win && host_req_i.addr[1:0] == OFS_CONTROL;
    assign mw = host_req_i.wr && win && host_req_i.addr[1:0] == OFS_MASK;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_req_atn_set: assert property (cw && host_req_i.wdata[2] |=> ctl_req_atn_o)
        else $error("request attention not set");
    a_req_atn_clr: assert property (ctl_req_i.clr_req_atn && !(cw && host_req_i.wdata[2])
        |=> !ctl_req_atn_o) else $error("request attention not cleared");
    a_req_atn_hold: assert property (!ctl_req_i.clr_req_atn && !cw
        |=> $stable(ctl_req_atn_o)) else $error("request attention moved");
    a_busy_toggle: assert property (cw && host_req_i.wdata[6]
        |=> ctl_host_busy_o != $past(ctl_host_busy_o)) else $error("host busy did not toggle");
    a_busy_hold: assert property (!cw |=> $stable(ctl_host_busy_o))
        else $error("host busy moved");
    a_rdata_hold: assert property (!host_req_i.rd |=> $stable(host_rdata_o))
        else $error("read data changed without read");
    a_outside_zero: assert property (host_req_i.rd && !win |=> host_rdata_o == 8'h00)
        else $error("read outside window not zero");
    a_ctl_read_fmt: assert property (host_req_i.rd && win && host_req_i.addr[1:0] == OFS_CONTROL
        |=> host_rdata_o[1:0] == 2'h0 && !host_rdata_o[5]
        && host_rdata_o[6] == $past(ctl_host_busy_o))
        else $error("control read layout wrong");
    a_mask_read_fmt: assert property (host_req_i.rd && win && host_req_i.addr[1:0] == OFS_MASK
        |=> host_rdata_o[7:2] == 6'h00) else $error("mask read layout wrong");
    a_refuse_cause: assert property (ctl_rsp_refused_o |-> $past(ctl_req_i.set_rsp_atn))
        else $error("refusal without response attention request");
    a_irq_disable: assert property (mw && !host_req_i.wdata[0] |=> !host_irq_o)
        else $error("interrupt stays with enable off");
endmodule // bt_mailbox_props

bind block_transfer_host_mailbox bt_mailbox_props #(.DEPTH(DEPTH), .IO_BASE(IO_BASE)) props_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .host_req_i(host_req_i), .host_rdata_o(host_rdata_o),
    .host_irq_o(host_irq_o), .ctl_req_i(ctl_req_i), .ctl_req_data_o(ctl_req_data_o),
    .ctl_req_atn_o(ctl_req_atn_o), .ctl_host_busy_o(ctl_host_busy_o),
    .ctl_rsp_refused_o(ctl_rsp_refused_o));

// *** verif/bt_ctl_model.sv ***
// Controller firmware model that answers each request through the mailbox.
`timescale 1ns/1ps
module bt_ctl_model (
    input wire logic clk_i,
    input wire logic [7:0] req_data_i,
    input wire logic req_atn_i,
    input wire logic slow_i,
    input wire logic bad_len_i,
    output bt_pkg::ctl_req_s ctl_o
);
    import bt_pkg::*;
    logic [7:0] rq [5];
    // Each strobe gets its own clock so no signal is written twice in a time step.
    task automatic put(input int k, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        ctl_o.rsp_wr = (k < 8);
        ctl_o.set_rsp_atn = (k == 8);
        ctl_o.clr_req_atn = (k == 9);
        ctl_o.set_sw_atn = (k == 10);
        ctl_o.rsp_idx = 8'(k);
        ctl_o.rsp_data = d;
        @(posedge clk_i);
        #1;
        ctl_o.rsp_wr = 1'b0;
        ctl_o.set_rsp_atn = 1'b0;
        ctl_o.clr_req_atn = 1'b0;
        ctl_o.set_sw_atn = 1'b0;
        ctl_o.rsp_data = ~d;
    endtask
    initial begin
        ctl_o = '0;
        forever begin
            while (req_atn_i !== 1'b1) @(posedge clk_i);
            #1;
            ctl_o.busy = 1'b1;
            for (int k = 0; k < 5; k++) begin
                ctl_o.req_idx = 8'(k);
                @(posedge clk_i);
                #1;
                rq[k] = req_data_i;
            end
            put(9, 8'h00);
            if (slow_i) repeat (40) @(posedge clk_i);
            if (bad_len_i) begin
                put(0, 8'h03);
                put(8, 8'h00);
            end
            put(0, 8'h05);
            put(1, rq[1] ^ 8'h04);
            put(2, rq[2]);
            put(3, rq[3]);
            put(4, 8'h00);
            put(5, rq[4]);
            // Software attention is raised ahead of the response so the host sees both.
            put(10, 8'h00);
            put(8, 8'h00);
            ctl_o.busy = 1'b0;
        end
    end
endmodule // bt_ctl_model

// *** verif/tb.sv ***
// Self-checking bench for the block-transfer host mailbox.
`timescale 1ns/1ps
module tb;
    import bt_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    host_req_s hq;
    ctl_req_s cq;
    logic [7:0] rdata, qdata;
    logic irq, atn, hbusy, refused;
    logic slow = 1'b0;
    logic bad = 1'b0;
    int num_errors = 0;
    int tests_run = 0;
    int refusals = 0;
    logic [7:0] lfsr_r = 8'h3e;
    logic [7:0] req_q[$];
    logic [7:0] exp_q[$];
    block_transfer_host_mailbox block_transfer_host_mailbox_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .host_req_i(hq), .host_rdata_o(rdata), .host_irq_o(irq), .ctl_req_i(cq),
        .ctl_req_data_o(qdata), .ctl_req_atn_o(atn), .ctl_host_busy_o(hbusy),
        .ctl_rsp_refused_o(refused));
    bt_ctl_model bt_ctl_model_inst (.clk_i(clk_i), .req_data_i(qdata), .req_atn_i(atn),
        .slow_i(slow), .bad_len_i(bad), .ctl_o(cq));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (refused === 1'b1) refusals++;
    end
    function automatic logic [7:0] rnd();
        lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        return lfsr_r;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic [1:0] ofs, input logic w, input logic [7:0] d,
                       output logic [7:0] v);
        @(negedge clk_i);
        hq.addr = {DEFAULT_IO_BASE[15:2], ofs};
        hq.rd = !w;
        hq.wr = w;
        hq.wdata = d;
        @(negedge clk_i);
        hq.rd = 1'b0;
        hq.wr = 1'b0;
        hq.wdata = ~d;
        v = rdata;
    endtask
    task automatic final_report();
        $display("counts: tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        final_report();
    end
    initial begin
        logic [7:0] v;
        int n;
        hq = '0;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i) rstn_i = 1'b1;
        for (int o = 0; o < 4; o++) begin
            acc(2'(o), 1'b0, 8'h00, v);
            check(v, 8'h00);
        end
        for (int k = 1; k >= 0; k--) begin
            acc(OFS_CONTROL, 1'b1, 8'h40, v);
            acc(OFS_CONTROL, 1'b0, 8'h00, v);
            check(v, {1'b0, k[0], 6'h00});
            check({7'h0, hbusy}, {7'h0, k[0]});
        end
        $display("test registers done");
        for (int i = 0; i < 2; i++) begin
            slow = (i == 0);
            bad = (i == 1);
            n = refusals;
            acc(OFS_MASK, 1'b1, {7'h0, slow}, v);
            req_q = {8'h04, rnd() & 8'hfc, 8'(i), rnd(), rnd()};
            exp_q = {8'h05, req_q[1] ^ 8'h04, req_q[2], req_q[3], 8'h00, req_q[4]};
            acc(OFS_CONTROL, 1'b1, 8'h01, v);
            foreach (req_q[k]) acc(OFS_BUFFER, 1'b1, req_q[k], v);
            check({7'h0, atn}, 8'h00);
            acc(OFS_CONTROL, 1'b1, 8'h04, v);
            check({7'h0, atn}, 8'h01);
            v = 8'h00;
            for (int w = 0; w < 300 && v[CTL_RSP_ATN] !== 1'b1; w++) acc(OFS_CONTROL, 1'b0, 8'h00, v);
            check(v & 8'h08, 8'h08);
            check(v & 8'h10, 8'h10);
            check({7'h0, irq}, {7'h0, slow});
            check(8'(refusals - n), {7'h0, bad});
            acc(OFS_CONTROL, 1'b1, 8'h02, v);
            foreach (exp_q[k]) begin
                acc(OFS_BUFFER, 1'b0, 8'h00, v);
                check(v, exp_q[k]);
            end
            acc(OFS_CONTROL, 1'b1, 8'h18, v);
            acc(OFS_CONTROL, 1'b0, 8'h00, v);
            check(v & 8'h18, 8'h00);
            acc(OFS_MASK, 1'b0, 8'h00, v);
            check(v, {6'h0, 1'b1, slow});
            acc(OFS_MASK, 1'b1, {6'h0, 1'b1, slow}, v);
            acc(OFS_MASK, 1'b0, 8'h00, v);
            check(v, {7'h0, slow});
            check({7'h0, irq}, 8'h00);
            $display("test message %0d done", i);
        end
        final_report();
    end
endmodule // tb
